// ===== rtl/ssfe_pkg.sv
// constants and types of the serial frame engine
// What this block does
// R01 - pulsed mode idle: clock, frame low, tristate
// R02 - pulsed mode: one-period frame pulse, load word
// R03 - pulsed mode: msb out on next rise
// R04 - pulsed mode: sample bits on falling edge
// R05 - pulsed mode: store word on rise after lsb
// R06 - polarity fixes idle clock level
// R07 - phase picks first or second capture edge
// R08 - spi idle: select high, data low, pad
// R09 - spi start: select low, enable data pad
// R10 - phase 0 slave drives bit at select
// R11 - pol0 ph0: bit, then rising clock
// R12 - pol0 ph1: bit with first rising edge
// R13 - pol1 ph0: bit, then falling clock
// R14 - pol1 ph1: bit with first falling edge
// R15 - select high one period after last sample
// R16 - phase 0: select pulses between words
// R17 - phase 0 slave needs select release
// R18 - phase 1: select stays low between words
// R19 - clock = system / (prescale * (1+rate))
// R20 - 4 to 16 bit frames, msb first
// R21 - independent 16x8 transmit and receive fifos
// R22 - word boundary: continue if fifo has data
// R23 - slave samples select and clock internally
package ssfe_pkg;
    localparam int          SSFE_DATA_W     = 16;
    localparam int          SSFE_FIFO_DEPTH = 8;
    localparam logic        FMT_PULSED      = 1'b0;
    localparam logic        FMT_SPI         = 1'b1;
    localparam logic        TXD_IDLE        = 1'b0;
    localparam logic        SEL_IDLE_SPI    = 1'b1;
    localparam logic [5:0]  TI_SEL_EDGE     = 6'd2;
    localparam logic [5:0]  TI_FIRST_SAMPLE = 6'd3;
    localparam logic [5:0]  TI_PUSH_OFS     = 6'd2;
    localparam logic [5:0]  TI_END_OFS      = 6'd3;
    localparam logic [1:0]  TAIL_PH0        = 2'd2;
    localparam logic [1:0]  TAIL_PH1        = 2'd3;
    localparam logic [1:0]  TAIL_RAISE      = 2'd2;
    localparam logic [1:0]  TAIL_LAST       = 2'd1;
    localparam logic [15:0] WORD_ONES       = 16'hffff;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_RUN  = 2'b11,
        ST_TAIL = 2'b10
    } ssfe_state_t;
endpackage

// ===== rtl/ssfe_engine.sv
// serial shift and framing engine with transmit and receive fifos
`timescale 1ns/100ps
module ssfe_engine import ssfe_pkg::*; #(
    parameter int FIFO_DEPTH = SSFE_FIFO_DEPTH
) (
    // clock and reset
    input  logic                         i_core_clk,
    input  logic                         i_rst_n,
    // configuration
    input  logic                         i_enable,
    input  logic                         i_master,
    input  logic                         i_frame_format,
    input  logic                         i_clock_polarity,
    input  logic                         i_clock_phase,
    input  logic [7:0]                   i_prescale_divisor,
    input  logic [7:0]                   i_clock_rate_divider,
    input  logic [3:0]                   i_data_size,
    // transmit fifo fill
    input  logic                         i_tx_push,
    input  logic [SSFE_DATA_W-1:0]       i_tx_data,
    output logic [$clog2(FIFO_DEPTH):0]  o_tx_level,
    // receive fifo drain
    input  logic                         i_rx_pop,
    output logic [SSFE_DATA_W-1:0]       o_rx_data,
    output logic                         o_rx_valid,
    output logic [$clog2(FIFO_DEPTH):0]  o_rx_level,
    output logic                         o_rx_overrun,
    input  logic                         i_rx_overrun_clr,
    // serial pins
    input  logic                         i_serial_clock_pin,
    output logic                         o_serial_clock_pin,
    output logic                         o_serial_clock_pin_oe_n,
    input  logic                         i_frame_select_pin,
    output logic                         o_frame_select_pin,
    output logic                         o_frame_select_pin_oe_n,
    output logic                         o_serial_transmit_pin,
    output logic                         o_serial_transmit_pin_oe_n,
    input  logic                         i_serial_receive_pin,
    // status
    output logic                         o_busy
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(FIFO_DEPTH);

    if (FIFO_DEPTH < 2 || (2 ** AW) != FIFO_DEPTH)
    begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [15:0]    tx_mem [FIFO_DEPTH];
    logic [15:0]    rx_mem [FIFO_DEPTH];
    logic [AW-1:0]  tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
    ssfe_state_t    state_reg;
    logic [5:0]     edge_reg;
    logic [1:0]     tail_reg;
    logic [15:0]    tx_sh_reg, rx_sh_reg, div_reg, push_data_reg;
    logic [3:0]     bit_reg;
    logic           act_reg, tipend_reg, sclk_d_reg, fss_d_reg, pop_reg, push_reg;
    logic           spi, tx_ok, tick, tx_push, rx_push_ok;
    logic           rise, fall, fss_fall, fss_rise, samp_on_rise, samp, shft, start;
    logic [6:0]     pre_half;
    logic [15:0]    half_len, ldw, sword, rx_in, rx_mask, rx_word;
    logic [5:0]     nlast, n2;

    // prescale is even, so half a serial period is (prescale/2)*(1+rate)
    always_comb
    begin
        spi          = i_frame_format == FMT_SPI;
        tx_ok        = i_enable && o_tx_level != '0;
        pre_half     = (i_prescale_divisor[7:1] == 7'd0) ? 7'd1 : i_prescale_divisor[7:1];
        half_len     = 16'(pre_half) * 16'({1'b0, i_clock_rate_divider} + 9'd1); // R19
        tick         = div_reg == half_len - 16'd1;
        ldw          = tx_mem[tx_rd_reg] << (4'd15 - i_data_size); // R20
        sword        = tx_ok ? ldw : 16'h0;
        rx_mask      = WORD_ONES >> (4'd15 - i_data_size);
        rx_in        = {rx_sh_reg[14:0], i_serial_receive_pin};
        rx_word      = rx_in & rx_mask;
        nlast        = {1'b0, i_data_size, 1'b1};
        n2           = {1'b0, i_data_size, 1'b0} + 6'd2;
        rise         = i_serial_clock_pin && !sclk_d_reg;
        fall         = !i_serial_clock_pin && sclk_d_reg;
        fss_fall     = !i_frame_select_pin && fss_d_reg;
        fss_rise     = i_frame_select_pin && !fss_d_reg;
        samp_on_rise = spi && !(i_clock_polarity ^ i_clock_phase); // R07
        samp         = samp_on_rise ? rise : fall; // R23
        shft         = samp_on_rise ? fall : rise;
        start        = spi ? fss_fall : (fall && i_frame_select_pin);
        tx_push      = i_tx_push && o_tx_level != FULL;
        rx_push_ok   = push_reg && o_rx_level != FULL;
    end

    // fifo storage carries no reset
    always_ff @(posedge i_core_clk)
    begin
        if (tx_push)
            tx_mem[tx_wr_reg] <= i_tx_data;
        if (rx_push_ok)
            rx_mem[rx_wr_reg] <= push_data_reg;
    end

    // transmit fifo pointers; a push into a full fifo is dropped
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_wr_reg  <= '0;
            tx_rd_reg  <= '0;
            o_tx_level <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wr_reg <= tx_wr_reg + 1'b1;
            if (pop_reg)
                tx_rd_reg <= tx_rd_reg + 1'b1;
            o_tx_level <= o_tx_level + (AW+1)'(tx_push) - (AW+1)'(pop_reg); // R21
        end
    end

    // receive fifo; overrun is sticky and a new overrun beats its clear
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_wr_reg    <= '0;
            rx_rd_reg    <= '0;
            o_rx_level   <= '0;
            o_rx_data    <= '0;
            o_rx_valid   <= 1'b0;
            o_rx_overrun <= 1'b0;
        end
        else
        begin
            o_rx_valid <= i_rx_pop && o_rx_level != '0;
            if (i_rx_pop && o_rx_level != '0)
            begin
                o_rx_data <= rx_mem[rx_rd_reg];
                rx_rd_reg <= rx_rd_reg + 1'b1;
            end
            if (rx_push_ok)
                rx_wr_reg <= rx_wr_reg + 1'b1;
            o_rx_level <= o_rx_level + (AW+1)'(rx_push_ok) - (AW+1)'(i_rx_pop && o_rx_level != '0); // R21
            if (push_reg && !rx_push_ok)
                o_rx_overrun <= 1'b1;
            else if (i_rx_overrun_clr)
                o_rx_overrun <= 1'b0;
        end
    end

    // half-period divider, held at zero outside a master transfer
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            div_reg <= '0;
        else if (!i_enable || !i_master || state_reg == ST_IDLE || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 16'd1; // R19
    end

    // serial engine: master sequencing and slave edge following
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg                  <= ST_IDLE;
            edge_reg                   <= '0;
            tail_reg                   <= '0;
            tx_sh_reg                  <= '0;
            rx_sh_reg                  <= '0;
            bit_reg                    <= '0;
            act_reg                    <= 1'b0;
            tipend_reg                 <= 1'b0;
            sclk_d_reg                 <= 1'b0;
            fss_d_reg                  <= 1'b1;
            pop_reg                    <= 1'b0;
            push_reg                   <= 1'b0;
            push_data_reg              <= '0;
            o_serial_clock_pin         <= 1'b0;
            o_serial_clock_pin_oe_n    <= 1'b1;
            o_frame_select_pin         <= 1'b0;
            o_frame_select_pin_oe_n    <= 1'b1;
            o_serial_transmit_pin      <= TXD_IDLE;
            o_serial_transmit_pin_oe_n <= 1'b1;
            o_busy                     <= 1'b0;
        end
        else
        begin
            pop_reg                 <= 1'b0;
            push_reg                <= 1'b0;
            sclk_d_reg              <= i_serial_clock_pin;
            fss_d_reg               <= i_frame_select_pin;
            o_serial_clock_pin_oe_n <= !i_master; // R08
            o_frame_select_pin_oe_n <= !i_master;
            o_busy                  <= state_reg != ST_IDLE || act_reg;
            if (!i_enable || (i_master && state_reg == ST_IDLE) || (!i_master && !act_reg))
            begin
                // idle pin levels follow the format
                o_serial_clock_pin         <= spi && i_clock_polarity; // R01 R06
                o_frame_select_pin         <= spi && SEL_IDLE_SPI; // R01 R08
                o_serial_transmit_pin      <= TXD_IDLE;
                o_serial_transmit_pin_oe_n <= 1'b1; // R01
            end
            if (!i_enable)
            begin
                state_reg  <= ST_IDLE;
                act_reg    <= 1'b0;
                tipend_reg <= 1'b0;
            end
            else if (i_master)
            begin
                act_reg <= 1'b0;
                unique case (state_reg)
                    ST_IDLE:
                    begin
                        if (tx_ok)
                        begin
                            tx_sh_reg <= ldw; // R02
                            pop_reg   <= 1'b1;
                            edge_reg  <= '0;
                            state_reg <= (spi && !i_clock_phase) ? ST_LEAD : ST_RUN; // R07
                            if (spi)
                            begin
                                o_frame_select_pin         <= 1'b0; // R09
                                o_serial_transmit_pin_oe_n <= 1'b0;
                            end
                        end
                    end
                    ST_LEAD:
                    begin
                        if (tick)
                        begin
                            o_serial_transmit_pin <= tx_sh_reg[15]; // R11 R13
                            tx_sh_reg             <= tx_sh_reg << 1;
                            state_reg             <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        if (tick)
                        begin
                            edge_reg           <= edge_reg + 6'd1;
                            o_serial_clock_pin <= !o_serial_clock_pin; // R19
                            if (spi)
                            begin
                                if (edge_reg[0] == i_clock_phase)
                                    rx_sh_reg <= rx_in; // R11 R12 R13 R14
                                else
                                begin
                                    o_serial_transmit_pin <= tx_sh_reg[15]; // R12 R14
                                    tx_sh_reg             <= tx_sh_reg << 1;
                                end
                                if (edge_reg == nlast - 6'(!i_clock_phase))
                                begin
                                    push_reg      <= 1'b1;
                                    push_data_reg <= rx_word;
                                end
                                if (edge_reg == nlast)
                                begin
                                    if (i_clock_phase && tx_ok)
                                    begin
                                        tx_sh_reg <= ldw; // R18 R22
                                        pop_reg   <= 1'b1;
                                        edge_reg  <= '0;
                                    end
                                    else
                                    begin
                                        state_reg <= ST_TAIL; // R16 R17 R22
                                        tail_reg  <= i_clock_phase ? TAIL_PH1 : TAIL_PH0;
                                    end
                                end
                            end
                            else if (!edge_reg[0])
                            begin
                                if (edge_reg == '0)
                                    o_frame_select_pin <= 1'b1; // R02
                                if (edge_reg == TI_SEL_EDGE)
                                begin
                                    o_frame_select_pin         <= 1'b0;
                                    o_serial_transmit_pin_oe_n <= 1'b0;
                                end
                                if (edge_reg >= TI_SEL_EDGE && edge_reg <= n2)
                                begin
                                    o_serial_transmit_pin <= tx_sh_reg[15]; // R03
                                    tx_sh_reg             <= tx_sh_reg << 1;
                                end
                                if (edge_reg == n2 + TI_PUSH_OFS)
                                begin
                                    push_reg      <= 1'b1; // R05
                                    push_data_reg <= rx_sh_reg & rx_mask;
                                    if (tx_ok)
                                    begin
                                        tx_sh_reg          <= ldw; // R02 R22
                                        pop_reg            <= 1'b1;
                                        o_frame_select_pin <= 1'b1;
                                        edge_reg           <= 6'd1;
                                    end
                                end
                            end
                            else
                            begin
                                if (edge_reg >= TI_FIRST_SAMPLE && edge_reg <= n2 + 6'd1)
                                    rx_sh_reg <= rx_in; // R04
                                if (edge_reg == n2 + TI_END_OFS)
                                    state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_TAIL:
                    begin
                        if (tick)
                        begin
                            tail_reg <= tail_reg - 2'd1;
                            if (tail_reg == TAIL_RAISE)
                            begin
                                o_frame_select_pin         <= 1'b1; // R15 R16
                                o_serial_transmit_pin_oe_n <= 1'b1;
                            end
                            if (tail_reg == TAIL_LAST)
                                state_reg <= ST_IDLE;
                        end
                    end
                endcase
            end
            else
            begin
                // slave: edges seen on registered pin samples
                state_reg <= ST_IDLE;
                if (start)
                begin
                    act_reg                    <= 1'b1;
                    tipend_reg                 <= 1'b0;
                    bit_reg                    <= '0;
                    pop_reg                    <= tx_ok;
                    tx_sh_reg                  <= sword;
                    o_serial_transmit_pin_oe_n <= !spi;
                    if (spi && !i_clock_phase)
                    begin
                        o_serial_transmit_pin <= sword[15]; // R10
                        tx_sh_reg             <= sword << 1;
                    end
                end
                else if (act_reg)
                begin
                    if (spi && fss_rise)
                        act_reg <= 1'b0; // R17
                    else if (shft && tipend_reg)
                    begin
                        push_reg   <= 1'b1; // R05
                        tipend_reg <= 1'b0;
                        act_reg    <= 1'b0;
                    end
                    else if (shft)
                    begin
                        o_serial_transmit_pin      <= tx_sh_reg[15]; // R23
                        o_serial_transmit_pin_oe_n <= 1'b0;
                        tx_sh_reg                  <= tx_sh_reg << 1;
                    end
                    else if (samp)
                    begin
                        rx_sh_reg <= rx_in; // R04 R23
                        bit_reg   <= bit_reg + 4'd1;
                        if (bit_reg == i_data_size)
                        begin
                            bit_reg       <= '0;
                            push_data_reg <= rx_word;
                            push_reg      <= spi;
                            tipend_reg    <= !spi;
                            if (spi && i_clock_phase)
                            begin
                                tx_sh_reg <= sword; // R18
                                pop_reg   <= tx_ok;
                            end
                        end
                    end
                end
            end
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    chk_ti_idle_pins: assert property ( // R01
        i_enable && i_master && !spi && state_reg == ST_IDLE && $past(state_reg) == ST_IDLE
        && $stable(i_frame_format) |-> !o_serial_clock_pin && !o_frame_select_pin && o_serial_transmit_pin_oe_n)
        else $error("pulsed idle pins wrong");
    chk_ti_pulse_fall: assert property ( // R02
        i_master && !spi && $fell(o_frame_select_pin) && $past(i_enable) && $past(state_reg) == ST_RUN
        |-> $past(edge_reg) == TI_SEL_EDGE && $past(tick))
        else $error("frame pulse not one period");
    chk_ti_push_time: assert property ( // R05
        i_master && !spi && push_reg && $past(state_reg) == ST_RUN |-> $past(edge_reg) == $past(n2) + TI_PUSH_OFS)
        else $error("pulsed word stored at wrong edge");
    chk_spi_idle_clk: assert property ( // R06
        i_enable && i_master && spi && state_reg == ST_IDLE && $past(state_reg) == ST_IDLE
        && $stable(i_clock_polarity) && $stable(i_frame_format) |-> o_serial_clock_pin == i_clock_polarity)
        else $error("idle clock level wrong");
    chk_spi_idle_sel: assert property ( // R08
        i_enable && spi && state_reg == ST_IDLE && !act_reg && $past(state_reg) == ST_IDLE && !$past(act_reg)
        && $stable(i_frame_format) && $stable(i_master)
        |-> o_frame_select_pin && !o_serial_transmit_pin && o_serial_clock_pin_oe_n == !i_master)
        else $error("spi idle pins wrong");
    chk_spi_start: assert property ( // R09
        i_master && spi && state_reg == ST_IDLE && tx_ok |=> !o_frame_select_pin && !o_serial_transmit_pin_oe_n)
        else $error("spi start wrong");
    chk_ph1_keep_sel: assert property ( // R18
        i_master && spi && i_clock_phase && state_reg == ST_RUN && tick && edge_reg == nlast && tx_ok
        |=> !o_frame_select_pin && state_reg == ST_RUN && edge_reg == 6'd0)
        else $error("select released between phase 1 words");
    chk_sel_release: assert property ( // R15
        $rose(o_frame_select_pin) && i_master && spi && $past(i_enable)
        |-> $past(state_reg) == ST_TAIL && $past(tail_reg) == TAIL_RAISE && $past(tick))
        else $error("select raised at wrong time");
    chk_clock_on_tick: assert property ( // R19
        i_master && state_reg == ST_RUN && $past(state_reg) == ST_RUN && $past(i_enable)
        && $changed(o_serial_clock_pin) |-> $past(tick))
        else $error("serial clock moved off the divider");
    chk_rx_width: assert property ( // R20
        push_reg && $stable(i_data_size) |-> (push_data_reg & ~rx_mask) == 16'h0)
        else $error("received word wider than frame");
    chk_fifo_bound: assert property ( // R21
        o_tx_level <= FULL && o_rx_level <= FULL)
        else $error("fifo level beyond depth");
endmodule

// ===== verif/ssfe_peer_model.sv
// far-side peer that echoes the engine data line back on receive
`timescale 1ns/100ps
module ssfe_peer_model (
    // clock
    input  wire logic i_core_clk,
    // lines seen from the engine
    input  wire logic i_txd,
    input  wire logic i_txd_oe_n,
    output logic      o_rxd
);
    logic last_reg = 1'b0;
    always_ff @(posedge i_core_clk)
    begin
        last_reg <= o_rxd;
    end
    // released line shows the inverse of the last bit, never a stale copy
    assign o_rxd = i_txd_oe_n ? ~last_reg : i_txd;
endmodule

// ===== verif/ssfe_engine_bench.sv
// self-checking bench for the serial frame engine as master, then as slave
`timescale 1ns/100ps
module ssfe_engine_bench;
    import ssfe_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        en = 1'b0, fmt = 1'b0, pol = 1'b0, ph = 1'b0;
    logic        push = 1'b0, pop = 1'b0;
    logic        mst = 1'b1, sci = 1'b0, fsi = 1'b1, ovc = 1'b0;
    logic [7:0]  presc = 8'h02, rate = 8'h00;
    logic [3:0]  dsz = 4'h7, txl, rxl;
    logic [15:0] txw = 16'h0000, rxd;
    logic        rxv, ovr, sclk, sclk_oe_n, fss, fss_oe_n, txd, txd_oe_n, rxp, busy;
    logic [1:0]  pm;
    int          nw, errors = 0, checks_done = 0, fss_act = 0;
    ssfe_engine dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_enable(en), .i_master(mst),
        .i_frame_format(fmt), .i_clock_polarity(pol), .i_clock_phase(ph), .i_prescale_divisor(presc),
        .i_clock_rate_divider(rate), .i_data_size(dsz), .i_tx_push(push), .i_tx_data(txw), .o_tx_level(txl),
        .i_rx_pop(pop), .o_rx_data(rxd), .o_rx_valid(rxv), .o_rx_level(rxl), .o_rx_overrun(ovr),
        .i_rx_overrun_clr(ovc), .i_serial_clock_pin(sci), .o_serial_clock_pin(sclk),
        .o_serial_clock_pin_oe_n(sclk_oe_n), .i_frame_select_pin(fsi), .o_frame_select_pin(fss),
        .o_frame_select_pin_oe_n(fss_oe_n), .o_serial_transmit_pin(txd),
        .o_serial_transmit_pin_oe_n(txd_oe_n), .i_serial_receive_pin(rxp), .o_busy(busy));
    ssfe_peer_model peer_u (.i_core_clk(clk), .i_txd(txd), .i_txd_oe_n(txd_oe_n), .o_rxd(rxp));
    initial
    begin
        forever #4 clk = ~clk;
    end
    // counts active frame edges: rises when pulsed, falls for spi
    always @(fss)
    begin
        if (rst_n && fss === ~fmt)
            fss_act++;
    end
    task automatic test_done();
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic push_word(input logic [15:0] w);
        txw = w;
        push = 1'b1;
        @(negedge clk);
        push = 1'b0;
        @(negedge clk);
    endtask
    task automatic pop_chk(input logic [15:0] exp);
        pop = 1'b1;
        @(negedge clk);
        pop = 1'b0;
        chk({15'h0, rxv}, 16'h0001);
        chk(rxd, exp);
        @(negedge clk);
    endtask
    // bounded wait for all words home and the engine idle
    task automatic wait_done(input int n);
        int k;
        for (k = 0; k < 3000 && !(rxl === 4'(n) && busy === 1'b0); k++)
            @(negedge clk);
        if (k == 3000)
        begin
            errors++;
            test_done();
        end
    endtask
    function automatic logic [15:0] word_of(input int k);
        return 16'ha5c3 ^ 16'(k * 16'h1b4f);
    endfunction
    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        // mode 0 pulsed frames with a full fifo, then the four spi modes
        for (int m = 0; m < 5; m++)
        begin
            nw = (m == 0) ? 8 : 2;
            pm = 2'(m - 1);
            en = 1'b0;
            fmt = (m != 0);
            pol = pm[1] & fmt;
            ph = pm[0] & fmt;
            presc = 8'(2 + 2 * (m % 2));
            rate = 8'(m / 2);
            dsz = (m == 4) ? 4'hf : 4'h7;
            repeat (4) @(negedge clk);
            en = (m != 0);
            repeat (4) @(negedge clk);
            fss_act = 0;
            for (int k = 0; k < nw + ((m == 0) ? 1 : 0); k++)
                push_word(word_of(k));
            if (m == 0)
            begin
                chk(16'(txl), 16'h0008);
                en = 1'b1;
            end
            wait_done(nw);
            chk(16'(fss_act), (m == 0) ? 16'h0008 : (ph ? 16'h0001 : 16'h0002));
            chk({10'h0, sclk, fss, txd_oe_n, sclk_oe_n, fss_oe_n, ovr}, {10'h0, pol, fmt, 4'h8});
            if (m == 0)
            begin
                // one more frame into a full receive fifo: word dropped, overrun sticks
                push_word(16'h0000);
                repeat (4) @(negedge clk);
                wait_done(nw);
                chk({15'h0, ovr}, 16'h0001);
                ovc = 1'b1;
                @(negedge clk);
                ovc = 1'b0;
                chk({11'h0, ovr, rxl}, 16'h0008);
            end
            for (int k = 0; k < nw; k++)
                pop_chk(word_of(k) & (WORD_ONES >> (15 - dsz)));
        end
        // slave, polarity 0 phase 0: bench drives clock and select, 12 core clocks a period
        en = 1'b0;
        mst = 1'b0;
        fmt = 1'b1;
        pol = 1'b0;
        ph = 1'b0;
        dsz = 4'h7;
        repeat (4) @(negedge clk);
        en = 1'b1;
        push_word(word_of(5));
        fsi = 1'b0;
        for (int b = 0; b < 17; b++)
        begin
            repeat (6) @(negedge clk);
            if (b < 16)
                sci = ~sci;
        end
        fsi = 1'b1;
        repeat (4) @(negedge clk);
        chk({13'h0, busy, sclk_oe_n, fss_oe_n}, 16'h0003);
        pop_chk(word_of(5) & 16'h00ff);
        test_done();
    end
endmodule
